// ==== include/ges_pkg.sv ====
package ges_pkg;

    // geometry of the block
    localparam int          NUM_PORTS     = 5;
    localparam int          ADR_W         = 12;
    localparam int          DAT_W         = 32;

    // register byte offsets
    localparam logic [11:0] OFF_EVT_CTL   = 12'h450;
    localparam logic [11:0] OFF_EVT_STS   = 12'h454;
    localparam logic [11:0] OFF_INT_STS   = 12'h460;
    localparam logic [11:0] OFF_INT_MASK  = 12'h464;
    localparam logic [11:0] OFF_PIN_FN    = 12'h468;
    localparam logic [11:0] OFF_SWING     = 12'h500;

    // field positions
    localparam int          INVERT_BIT    = 0;
    localparam int          PORT_LSB      = 1;
    localparam int          SWING_BIT     = 8;
    localparam int          ALT_FN_BIT    = 0;
    localparam int          PIN_LEVEL_BIT = 1;

    // reset values
    localparam logic [4:0]  RST_ENABLES   = 5'h00;
    localparam logic [4:0]  RST_STATUS    = 5'h00;
    localparam logic [4:0]  RST_MASK      = 5'h00;
    localparam logic        RST_INVERT    = 1'h0;
    localparam logic        RST_SWING     = 1'h0;
    localparam logic        RST_ALT_FN    = 1'h0;

endpackage : ges_pkg

// ==== rtl/ges_event_port.sv ====
`timescale 1ns/1ps
module ges_event_port (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // control and request
    input  wire logic enable_in,
    input  wire logic notify_in,
    // results
    output logic      flag_out,
    output logic      suppress_out,
    output logic      std_notify_out
);

    // flag follows the port request only while routing to the event pin
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_out <= 1'h0;
        end else begin
            flag_out <= enable_in & notify_in; // R1 R2
        end
    end

    // standard notifications are held off while the event route is chosen
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            suppress_out   <= 1'h0;
            std_notify_out <= 1'h0;
        end else begin
            suppress_out   <= enable_in; // R7
            std_notify_out <= notify_in & ~enable_in; // R7
        end
    end

endmodule : ges_event_port

// ==== rtl/ges_pin_drive.sv ====
`timescale 1ns/1ps
module ges_pin_drive (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // event and configuration
    input  wire logic event_in,
    input  wire logic invert_in,
    input  wire logic alt_fn_in,
    // pin
    output logic      pin_out,
    output logic      pin_oe_out
);

    // drive only in alternate function; otherwise release the pin
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_out    <= 1'h0;
            pin_oe_out <= 1'h0;
        end else begin
            pin_oe_out <= alt_fn_in; // R3
            // active low unless inverted
            pin_out    <= alt_fn_in & (invert_in ? event_in : ~event_in); // R3 R6
        end
    end

endmodule : ges_pin_drive

// ==== rtl/ges_top.sv ====
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// R1: status bits 1..5 read one while that port asserts the shared event output
// R2: a port status bit never sets unless that port's event enable is set
// R3: shared event drives pin 7 only when the pin is in alternate function
// R4: status bits are read-only, reset zero; bit 0 and bits 31:6 read zero
// R5: sticky bit 8 of serdes control resets zero; one selects low swing
// R6: event output is active low, active high when the invert bit is set
// R7: enabled ports suppress standard hot-plug, MSI, PME and use the event output
// R8: shared event output is asserted whenever any port status bit is set
module ges_top #(
    parameter int NUM_PORTS = ges_pkg::NUM_PORTS
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    // wishbone slave
    input  wire logic                  wb_cyc_in,
    input  wire logic                  wb_stb_in,
    input  wire logic                  wb_we_in,
    input  wire logic [11:0]           wb_adr_in,
    input  wire logic [3:0]            wb_sel_in,
    input  wire logic [31:0]           wb_dat_in,
    output logic      [31:0]           wb_dat_out,
    output logic                       wb_ack_out,
    // downstream port notifications
    input  wire logic [NUM_PORTS-1:0]  port_notify_in,
    output logic      [NUM_PORTS-1:0]  port_std_notify_out,
    output logic      [NUM_PORTS-1:0]  port_notify_suppress_out,
    // general purpose pin 7
    input  wire logic                  gpio7_in,
    output logic                       gpio7_out,
    output logic                       gpio7_oe_out,
    // serdes and interrupt
    output logic                       low_swing_out,
    output logic                       irq_out
);

    // software state
    logic [NUM_PORTS-1:0] enables_q;
    logic                 invert_q;
    logic                 alt_fn_q;
    logic                 swing_q;
    logic [NUM_PORTS-1:0] mask_q;
    // hardware state
    logic [NUM_PORTS-1:0] status_w;
    logic [NUM_PORTS-1:0] status_prev_q;
    logic [NUM_PORTS-1:0] int_sts_q;
    logic [NUM_PORTS-1:0] int_sts_d;
    logic                 shared_event_q;
    logic                 pin_level_q;
    // bus state
    logic                 ack_q;
    logic [31:0]          dat_q;
    logic [31:0]          rd_data;
    logic                 req;
    logic                 wr_ctl;
    logic                 wr_mask;
    logic                 wr_pin;
    logic                 wr_swing;
    logic                 rd_int;

    // every check here runs on the core clock and sleeps through reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // word decode shared by read and write paths
    function automatic logic reg_hit(input logic [11:0] adr, input logic [11:0] off);
        reg_hit = (adr[11:2] == off[11:2]);
    endfunction : reg_hit

    // place a port vector at bits 1..5 of a word
    function automatic logic [31:0] port_word(input logic [NUM_PORTS-1:0] v);
        port_word = 32'h0;
        port_word[ges_pkg::PORT_LSB +: NUM_PORTS] = v;
    endfunction : port_word

    // one new request per transfer; ack_q gates a held request out
    assign req      = wb_cyc_in & wb_stb_in & ~ack_q;
    assign wr_ctl   = req & wb_we_in & reg_hit(wb_adr_in, ges_pkg::OFF_EVT_CTL) & wb_sel_in[0];
    assign wr_mask  = req & wb_we_in & reg_hit(wb_adr_in, ges_pkg::OFF_INT_MASK) & wb_sel_in[0];
    assign wr_pin   = req & wb_we_in & reg_hit(wb_adr_in, ges_pkg::OFF_PIN_FN) & wb_sel_in[0];
    assign wr_swing = req & wb_we_in & reg_hit(wb_adr_in, ges_pkg::OFF_SWING) & wb_sel_in[1];
    assign rd_int   = req & ~wb_we_in & reg_hit(wb_adr_in, ges_pkg::OFF_INT_STS);

    // per-port event flag and notification steering
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            ges_event_port u_port (
                .clk_in         (clk_in),
                .sys_rst_in     (sys_rst_in),
                .enable_in      (enables_q[gi]),
                .notify_in      (port_notify_in[gi]),
                .flag_out       (status_w[gi]),
                .suppress_out   (port_notify_suppress_out[gi]),
                .std_notify_out (port_std_notify_out[gi])
            );
        end
    endgenerate

    // all ports share one event line
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shared_event_q <= 1'h0;
        end else begin
            shared_event_q <= |status_w; // R8
        end
    end

    // pin mux and polarity
    ges_pin_drive u_pin (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .event_in   (shared_event_q),
        .invert_in  (invert_q),
        .alt_fn_in  (alt_fn_q),
        .pin_out    (gpio7_out),
        .pin_oe_out (gpio7_oe_out)
    );

    // pin level readback, taken as synchronous
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_level_q <= 1'h0;
        end else begin
            pin_level_q <= gpio7_in;
        end
    end

    // event control: polarity and per-port enables, byte lane 0
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            invert_q  <= ges_pkg::RST_INVERT;
            enables_q <= ges_pkg::RST_ENABLES;
        end else if (wr_ctl) begin
            invert_q  <= wb_dat_in[ges_pkg::INVERT_BIT]; // R6
            enables_q <= wb_dat_in[ges_pkg::PORT_LSB +: NUM_PORTS]; // R7
        end
    end

    // pin function select
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            alt_fn_q <= ges_pkg::RST_ALT_FN;
        end else if (wr_pin) begin
            alt_fn_q <= wb_dat_in[ges_pkg::ALT_FN_BIT]; // R3
        end
    end

    // swing select; sticky bits share the core reset here, no aux power domain
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            swing_q <= ges_pkg::RST_SWING;
        end else if (wr_swing) begin
            swing_q <= wb_dat_in[ges_pkg::SWING_BIT]; // R5
        end
    end

    // low swing goes to the transmitter straight from the flop
    assign low_swing_out = swing_q;

    // interrupt mask
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mask_q <= ges_pkg::RST_MASK;
        end else if (wr_mask) begin
            mask_q <= wb_dat_in[ges_pkg::PORT_LSB +: NUM_PORTS];
        end
    end

    // a rising port flag is the event; set wins over the read clear
    always_comb begin
        int_sts_d = int_sts_q;
        if (rd_int) begin
            int_sts_d = '0;
        end
        int_sts_d = int_sts_d | (status_w & ~status_prev_q);
    end

    // sticky interrupt status and level output
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_prev_q <= ges_pkg::RST_STATUS;
            int_sts_q     <= ges_pkg::RST_STATUS;
            irq_out       <= 1'h0;
        end else begin
            status_prev_q <= status_w;
            int_sts_q     <= int_sts_d;
            irq_out       <= |(int_sts_d & mask_q);
        end
    end

    // read mux; unmapped words answer zero
    always_comb begin
        rd_data = 32'h0;
        if (reg_hit(wb_adr_in, ges_pkg::OFF_EVT_STS)) begin
            rd_data = port_word(status_w); // R4
        end else if (reg_hit(wb_adr_in, ges_pkg::OFF_EVT_CTL)) begin
            rd_data = port_word(enables_q);
            rd_data[ges_pkg::INVERT_BIT] = invert_q;
        end else if (reg_hit(wb_adr_in, ges_pkg::OFF_INT_STS)) begin
            rd_data = port_word(int_sts_q);
        end else if (reg_hit(wb_adr_in, ges_pkg::OFF_INT_MASK)) begin
            rd_data = port_word(mask_q);
        end else if (reg_hit(wb_adr_in, ges_pkg::OFF_PIN_FN)) begin
            rd_data[ges_pkg::ALT_FN_BIT]    = alt_fn_q;
            rd_data[ges_pkg::PIN_LEVEL_BIT] = pin_level_q;
        end else if (reg_hit(wb_adr_in, ges_pkg::OFF_SWING)) begin
            rd_data[ges_pkg::SWING_BIT] = swing_q;
        end
    end

    // ack one cycle after the request; writes to read-only words are dropped
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'h0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= req;
            dat_q <= (req & ~wb_we_in) ? rd_data : 32'h0;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = dat_q;

    // checks on what this block drives
    genvar ai;
    generate
        for (ai = 0; ai < NUM_PORTS; ai++) begin : g_chk
            a_flag_needs_enable: assert property ( // R2
                status_w[ai] |-> $past(enables_q[ai]))
                else $error("port flag set without enable");
            a_flag_follows_port: assert property ( // R1
                $rose(port_notify_in[ai]) && enables_q[ai] |=> status_w[ai])
                else $error("port flag did not follow request");
            a_std_path_suppressed: assert property ( // R7
                port_std_notify_out[ai] |-> !port_notify_suppress_out[ai])
                else $error("standard notify while suppressed");
        end
    endgenerate

    a_status_reserved_zero: assert property ( // R4
        req && !wb_we_in && reg_hit(wb_adr_in, ges_pkg::OFF_EVT_STS)
        |=> wb_ack_out && wb_dat_out[0] == 1'h0 && wb_dat_out[31:6] == 26'h0)
        else $error("status reserved bits not zero");

    a_status_read_only: assert property ( // R4
        wr_ctl == 1'h0 && $stable(port_notify_in) && $stable(enables_q)
        ##1 $stable(port_notify_in) |=> $stable(status_w))
        else $error("status changed with no cause");

    a_event_any_port: assert property ( // R8
        (|status_w) |=> shared_event_q)
        else $error("shared event not asserted");

    a_pin_released: assert property ( // R3
        !alt_fn_q |=> !gpio7_oe_out && !gpio7_out)
        else $error("pin driven outside alternate function");

    a_pin_polarity: assert property ( // R6
        alt_fn_q |=> gpio7_out == ($past(shared_event_q) ~^ $past(invert_q)))
        else $error("pin level wrong for polarity");

    a_swing_write: assert property ( // R5
        wr_swing |=> ##1 low_swing_out == $past(wb_dat_in[ges_pkg::SWING_BIT], 2))
        else $error("swing bit not written");

    a_ack_single: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held two cycles");

    a_irq_masked: assert property (
        irq_out |-> $past(mask_q) != '0)
        else $error("interrupt with all masked");

    c_port_event: cover property (
        alt_fn_q && !shared_event_q ##1 shared_event_q ##1 gpio7_oe_out);
    c_inverted_event: cover property (
        invert_q && shared_event_q ##1 gpio7_out);
    c_low_swing: cover property (
        wr_swing ##2 low_swing_out);
    c_irq_read_clear: cover property (
        irq_out ##1 rd_int ##1 !irq_out);

endmodule : ges_top

// ==== tb/ges_evt_rx.sv ====
`timescale 1ns/1ps
module ges_evt_rx (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // pin as driven by the switch
    input  wire logic pin_drv_in,
    input  wire logic pin_oe_in,
    input  wire logic invert_in,
    // resolved pin and decoded event
    output logic      pin_level_out,
    output logic      event_seen_out
);
    logic last_q;

    // no pull on this net; a released pin shows the inverse of the last driven level,
    // so a stale value can never pass for a driven one
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            last_q <= 1'h0;
        end else if (pin_oe_in) begin
            last_q <= pin_drv_in;
        end
    end

    // wire level from the only driver, decoded with the polarity software chose
    assign pin_level_out  = pin_oe_in ? pin_drv_in : ~last_q;
    assign event_seen_out = pin_oe_in & (pin_level_out == invert_in);
endmodule : ges_evt_rx

// ==== tb/ges_top_tb.sv ====
`timescale 1ns/1ps
module ges_top_tb;
    logic        clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, inv;
    logic [11:0] wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out, rd;
    logic        wb_ack_out, gpio7_out, gpio7_oe_out, low_swing_out, irq_out, pin, seen;
    logic [4:0]  port_notify_in, std_n, supp;
    int          err_count, n_checks;

    ges_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .port_notify_in(port_notify_in),
        .port_std_notify_out(std_n), .port_notify_suppress_out(supp), .gpio7_in(pin),
        .gpio7_out(gpio7_out), .gpio7_oe_out(gpio7_oe_out),
        .low_swing_out(low_swing_out), .irq_out(irq_out));
    ges_evt_rx rx_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_drv_in(gpio7_out),
        .pin_oe_in(gpio7_oe_out), .invert_in(inv), .pin_level_out(pin),
        .event_seen_out(seen));

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (exp !== got) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic single cycle; waits on ack, never assumes a latency
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_dat_in <= wd;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'h1 && n < 20);
        rd = wb_dat_out;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
        wb_we_in  <= 1'h0;
    endtask : wb

    task automatic rchk(input string what, input logic [11:0] adr, input logic [31:0] exp);
        wb(1'h0, adr, 32'h0);
        chk(what, exp, rd);
    endtask : rchk

    // let the event pipeline land, then sample off the edge
    task automatic settle(input logic [4:0] nt);
        @(posedge clk_in);
        port_notify_in <= nt;
        repeat (4) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic t_reset_and_ro();
        chk("oe after reset", 32'h0, {31'h0, gpio7_oe_out});
        rchk("status reset", 12'h454, 32'h0);
        rchk("swing reset", 12'h500, 32'h0);
        wb(1'h1, 12'h454, 32'hffffffff);
        rchk("status ro", 12'h454, 32'h0);
        rchk("unmapped", 12'h7fc, 32'h0);
        $display("test reset_and_ro done");
    endtask : t_reset_and_ro

    task automatic t_swing();
        wb(1'h1, 12'h500, 32'hffffffff);
        rchk("swing set", 12'h500, 32'h00000100);
        chk("low swing out", 32'h1, {31'h0, low_swing_out});
        wb(1'h1, 12'h500, 32'h0);
        #1;
        chk("full swing out", 32'h0, {31'h0, low_swing_out});
        $display("test swing done");
    endtask : t_swing

    task automatic t_disabled();
        settle(5'h1f);
        rchk("status disabled", 12'h454, 32'h0);
        chk("std path", 32'h1f, {27'h0, std_n});
        chk("pin idle", 32'h0, {31'h0, gpio7_oe_out});
        settle(5'h00);
        $display("test disabled done");
    endtask : t_disabled

    task automatic t_ports();
        wb(1'h1, 12'h450, 32'h0000003e);
        wb(1'h1, 12'h468, 32'h00000001);
        wb(1'h1, 12'h464, 32'h0000003e);
        settle(5'h00);
        rchk("pin fn idle high", 12'h468, 32'h3);
        for (int i = 0; i < 5; i++) begin
            settle(5'h01 << i);
            chk("pin low", 32'h0, {31'h0, gpio7_out});
            chk("event seen", 32'h1, {31'h0, seen});
            chk("std muted", 32'h0, {27'h0, std_n});
            chk("suppress", 32'h1f, {27'h0, supp});
            chk("irq", 32'h1, {31'h0, irq_out});
            rchk("port status", 12'h454, 32'h1 << (i + 1));
            rchk("int status", 12'h460, 32'h1 << (i + 1));
            settle(5'h01 << i);
            chk("irq cleared", 32'h0, {31'h0, irq_out});
            settle(5'h00);
            chk("pin idle", 32'h1, {31'h0, gpio7_out});
        end
        $display("test ports done");
    endtask : t_ports

    task automatic t_mask_invert();
        wb(1'h1, 12'h464, 32'h0);
        settle(5'h01);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        wb(1'h1, 12'h464, 32'h0000003e);
        settle(5'h01);
        chk("irq unmasked", 32'h1, {31'h0, irq_out});
        rchk("int clear", 12'h460, 32'h2);
        wb(1'h1, 12'h450, 32'h0000003f);
        inv <= 1'h1;
        settle(5'h10);
        chk("pin high", 32'h1, {31'h0, gpio7_out});
        chk("event inv", 32'h1, {31'h0, seen});
        settle(5'h00);
        chk("pin inv idle", 32'h0, {31'h0, gpio7_out});
        wb(1'h1, 12'h468, 32'h0);
        settle(5'h1f);
        chk("alt off oe", 32'h0, {31'h0, gpio7_oe_out});
        chk("alt off pin", 32'h0, {31'h0, gpio7_out});
        rchk("pin released", 12'h468, 32'h2);
        rchk("status all", 12'h454, 32'h3e);
        $display("test mask_invert done");
    endtask : t_mask_invert

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    // watchdog: the run needs well under 3000 cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        end_of_test();
    end

    initial begin
        {wb_cyc_in, wb_stb_in, wb_we_in, inv} = 4'h0;
        {wb_adr_in, wb_dat_in, port_notify_in} = '0;
        wb_sel_in = 4'hf;
        err_count = 0;
        n_checks = 0;
        sys_rst_in = 1'h1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        t_reset_and_ro();
        t_swing();
        t_disabled();
        t_ports();
        t_mask_invert();
        end_of_test();
    end
endmodule : ges_top_tb
